// *** src/dqos_bridge.sv ***
// QoS front end of the shared-to-DRAM bridge with its APB registers.
`timescale 1ns/1ps
`default_nettype none
module dqos_bridge
  import dqos_pkg::*;
(
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [PADDR_W-1:0]     paddr,
  input  wire logic [31:0]            pwdata,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   cmd_valid,
  output logic                        cmd_ready,
  input  wire dqos_pkg::dqos_bus_cmd_t cmd_in,
  output logic                        dram_valid,
  input  wire logic                   dram_ready,
  output dqos_pkg::dqos_dram_cmd_t    dram_cmd
);
  logic [8:0]       rng_r [NRANGE];
  logic [MAP_W-1:0] map_r [2][4];
  logic             is_rt;
  logic             cmd_fire;
  logic             hi_push;
  logic             lo_push;
  logic [MAP_W-1:0] sel_map;
  logic [NRANGE-1:0] rng_hit;
  dqos_slot_t       push_cmd;
  logic             hi_pop;
  logic             lo_pop;
  logic             load;
  logic [DEPTH-1:0] lo_hit;
  logic [DEPTH-1:0] lo_pop_mask;
  logic             hi_sel_valid;
  logic             lo_sel_valid;
  dqos_slot_t       hi_sel_cmd;
  dqos_slot_t       lo_sel_cmd;
  logic [CNT_W-1:0] hi_cnt;
  logic [CNT_W-1:0] lo_cnt;
  logic             hi_full;
  logic             lo_full;
  logic             hi_blk;
  logic             reg_ok;
  logic             is_rng;
  logic             is_map;
  logic [1:0]       rng_idx;
  logic             map_hi;
  logic [1:0]       map_idx;
  logic [7:0]       map_off;
  logic             wr_en;
  logic [31:0]      rd_val;
  logic             dram_valid_r;
  dqos_dram_cmd_t   dram_cmd_r;

  // Class sorting: only bus thread 2 is real-time, the rest is normal.
  always_comb begin
    is_rt     = (cmd_in.thread == THREAD_REALTIME);
    cmd_ready = is_rt ? !hi_full : !lo_full;
    cmd_fire  = cmd_valid && cmd_ready;
    hi_push   = cmd_fire && is_rt;
    lo_push   = cmd_fire && !is_rt;
  end

  // Range match and priority translation done at arrival time.
  always_comb begin
    sel_map = map_r[is_rt][0];
    for (int k = NRANGE - 1; k >= 0; k--) begin
      rng_hit[k] = rng_r[k][RNG_EN_BIT] &&
                   cmd_in.prio >= rng_r[k][RNG_LO_LSB +: 3] &&
                   cmd_in.prio <= rng_r[k][RNG_HI_LSB +: 3];
      if (rng_hit[k]) begin
        sel_map = map_r[is_rt][k + 1];
      end
    end
    push_cmd.prio  = sel_map[cmd_in.prio * 3 +: 3];
    push_cmd.addr  = cmd_in.addr;
    push_cmd.write = cmd_in.write;
  end

  // Output stage loads when empty or when the DRAM side takes it.
  always_comb begin
    load   = !dram_valid_r || dram_ready;
    hi_pop = load && hi_sel_valid;
    lo_pop = load && !hi_sel_valid && lo_sel_valid;
  end

  dqos_cmd_queue u_high_q (
    .pclk      (pclk),
    .presetn   (presetn),
    .push      (hi_push),
    .push_cmd  (push_cmd),
    .push_blk  (lo_hit),
    .clr_blk   (lo_pop_mask),
    .cmp_addr  (cmd_in.addr),
    .cmp_hit   (),
    .pop       (hi_pop),
    .sel_valid (hi_sel_valid),
    .sel_idx   (),
    .sel_cmd   (hi_sel_cmd),
    .pop_mask  (),
    .count     (hi_cnt),
    .full      (hi_full),
    .blk_any   (hi_blk)
  );

  dqos_cmd_queue u_low_q (
    .pclk      (pclk),
    .presetn   (presetn),
    .push      (lo_push),
    .push_cmd  (push_cmd),
    .push_blk  ('0),
    .clr_blk   ('0),
    .cmp_addr  (cmd_in.addr),
    .cmp_hit   (lo_hit),
    .pop       (lo_pop),
    .sel_valid (lo_sel_valid),
    .sel_idx   (),
    .sel_cmd   (lo_sel_cmd),
    .pop_mask  (lo_pop_mask),
    .count     (lo_cnt),
    .full      (lo_full),
    .blk_any   ()
  );

  // Registered command towards the DRAM controller.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dram_valid_r <= 1'b0;
      dram_cmd_r   <= '0;
    end else if (load) begin
      dram_valid_r <= hi_sel_valid || lo_sel_valid;
      if (hi_sel_valid) begin
        dram_cmd_r <= {1'b1, hi_sel_cmd};
      end else if (lo_sel_valid) begin
        dram_cmd_r <= {1'b0, lo_sel_cmd};
      end
    end
  end

  assign dram_valid = dram_valid_r;
  assign dram_cmd   = dram_cmd_r;

  // APB address decode over the register map.
  always_comb begin
    map_off = paddr - OFF_MAP_BASE;
    rng_idx = paddr[3:2];
    map_hi  = map_off[4];
    map_idx = map_off[3:2];
    is_rng  = 1'b0;
    is_map  = 1'b0;
    reg_ok  = 1'b0;
    if (paddr[1:0] != 2'b00) begin
      reg_ok = 1'b0;
    end else if (paddr < OFF_MAP_BASE) begin
      is_rng = 1'b1;
      reg_ok = 1'b1;
    end else if (paddr < OFF_STATUS) begin
      is_map = 1'b1;
      reg_ok = 1'b1;
    end else if (paddr == OFF_STATUS) begin
      reg_ok = 1'b1;
    end
    wr_en = psel && penable && pwrite && reg_ok;
  end

  // Read data selection; status shows queue state.
  always_comb begin
    rd_val = '0;
    if (is_rng) begin
      rd_val[8:0] = rng_r[rng_idx];
    end else if (is_map) begin
      rd_val[MAP_W-1:0] = map_r[map_hi][map_idx];
    end else if (reg_ok) begin
      rd_val[ST_HI_CNT_LSB +: CNT_W] = hi_cnt;
      rd_val[ST_LO_CNT_LSB +: CNT_W] = lo_cnt;
      rd_val[ST_BLK_BIT]             = hi_blk;
    end
    prdata  = (psel && penable && !pwrite) ? rd_val : '0;
    pready  = 1'b1;
    pslverr = psel && penable && !reg_ok;
  end

  // Range match registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int k = 0; k < NRANGE; k++) begin
        rng_r[k] <= RNG_RESET;
      end
    end else if (wr_en && is_rng) begin
      rng_r[rng_idx] <= pwdata[8:0] & RNG_MASK;
    end
  end

  // Priority map registers, index 0 default then ranges 1 to 3.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int t = 0; t < 2; t++) begin
        for (int k = 0; k < 4; k++) begin
          map_r[t][k] <= MAP_RESET;
        end
      end
    end else if (wr_en && is_map) begin
      map_r[map_hi][map_idx] <= pwdata[MAP_W-1:0];
    end
  end

  a_rt_sort:
  assert property (@(posedge pclk) disable iff (!presetn)
    cmd_fire && cmd_in.thread == THREAD_REALTIME && !hi_pop
    |=> hi_cnt == $past(hi_cnt) + 3'd1)
    else $error("Thread 2 command did not enter the high thread.");

  a_nrt_sort:
  assert property (@(posedge pclk) disable iff (!presetn)
    cmd_fire && cmd_in.thread == THREAD_NONREALTIME && !lo_pop
    |=> lo_cnt == $past(lo_cnt) + 3'd1)
    else $error("Thread 0 command did not enter the low thread.");

  a_other_to_low:
  assert property (@(posedge pclk) disable iff (!presetn)
    cmd_fire && cmd_in.thread[0] && !lo_pop
    |=> lo_cnt == $past(lo_cnt) + 3'd1)
    else $error("Unclassed command was not treated as normal traffic.");

  a_rt_reserve:
  assert property (@(posedge pclk) disable iff (!presetn)
    cmd_valid && is_rt && hi_cnt < 3'd4 |-> cmd_ready)
    else $error("Real-time command refused while its space was free.");

  a_high_first:
  assert property (@(posedge pclk) disable iff (!presetn)
    load && hi_sel_valid && lo_sel_valid
    |=> dram_valid && dram_cmd.high_prio_thread)
    else $error("Normal command served ahead of a ready real-time one.");

  a_high_moves:
  assert property (@(posedge pclk) disable iff (!presetn)
    hi_sel_valid && !dram_valid ##1 dram_ready [*2]
    |-> $past(hi_cnt, 2) > hi_cnt || dram_cmd.high_prio_thread)
    else $error("High thread stalled behind the low thread.");

  a_conflict_hold:
  assert property (@(posedge pclk) disable iff (!presetn)
    hi_push && lo_hit != '0 && !lo_pop |=> hi_blk)
    else $error("Conflicting high command was not held.");

  a_default_map:
  assert property (@(posedge pclk) disable iff (!presetn)
    cmd_fire && !is_rt && rng_hit == '0 |->
    push_cmd.prio == map_r[0][0][cmd_in.prio * 3 +: 3])
    else $error("Unmatched priority did not use the default map.");
endmodule
`default_nettype wire

// *** src/dqos_cmd_queue.sv ***
// One thread's command queue with age tracking and priority pick.
`timescale 1ns/1ps
`default_nettype none
module dqos_cmd_queue
  import dqos_pkg::*;
(
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 push,
  input  wire dqos_pkg::dqos_slot_t push_cmd,
  input  wire logic [DEPTH-1:0]     push_blk,
  input  wire logic [DEPTH-1:0]     clr_blk,
  input  wire logic [ADDR_W-1:0]    cmp_addr,
  output logic [DEPTH-1:0]          cmp_hit,
  input  wire logic                 pop,
  output logic                      sel_valid,
  output logic [IDX_W-1:0]          sel_idx,
  output dqos_pkg::dqos_slot_t      sel_cmd,
  output logic [DEPTH-1:0]          pop_mask,
  output logic [CNT_W-1:0]          count,
  output logic                      full,
  output logic                      blk_any
);
  dqos_slot_t       slot_r   [DEPTH];
  logic [DEPTH-1:0] valid_r;
  logic [DEPTH-1:0] older_r  [DEPTH];
  logic [DEPTH-1:0] blk_r    [DEPTH];
  logic [DEPTH-1:0] elig;
  logic [IDX_W-1:0] free_idx;

  // Free slot search, eligibility, address compare and occupancy.
  always_comb begin
    free_idx = '0;
    count    = '0;
    blk_any  = 1'b0;
    for (int i = DEPTH - 1; i >= 0; i--) begin
      if (!valid_r[i]) begin
        free_idx = IDX_W'(i);
      end
    end
    for (int i = 0; i < DEPTH; i++) begin
      elig[i]    = valid_r[i] && (blk_r[i] == '0);
      cmp_hit[i] = valid_r[i] && (slot_r[i].addr == cmp_addr);
      count      = count + CNT_W'(valid_r[i]);
      blk_any    = blk_any | (valid_r[i] && (blk_r[i] != '0));
    end
    full = (valid_r == '1);
  end

  // Pick the most urgent eligible slot, oldest first on a tie.
  always_comb begin
    logic win;
    win       = 1'b0;
    sel_valid = 1'b0;
    sel_idx   = '0;
    for (int i = 0; i < DEPTH; i++) begin
      win = elig[i];
      for (int j = 0; j < DEPTH; j++) begin
        if (j != i && elig[j] && (slot_r[j].prio < slot_r[i].prio ||
            (slot_r[j].prio == slot_r[i].prio && older_r[i][j]))) begin
          win = 1'b0;
        end
      end
      if (win && !sel_valid) begin
        sel_valid = 1'b1;
        sel_idx   = IDX_W'(i);
      end
    end
    sel_cmd  = slot_r[sel_idx];
    pop_mask = (pop && sel_valid) ? (DEPTH'(1) << sel_idx) : '0;
  end

  // Slot payload and occupancy.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      valid_r <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        slot_r[i] <= '0;
      end
    end else begin
      valid_r <= (valid_r & ~pop_mask) |
                 (push ? (DEPTH'(1) << free_idx) : '0);
      if (push) begin
        slot_r[free_idx] <= push_cmd;
      end
    end
  end

  // Age matrix and address-conflict holds per slot.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        older_r[i] <= '0;
        blk_r[i]   <= '0;
      end
    end else begin
      for (int i = 0; i < DEPTH; i++) begin
        older_r[i] <= older_r[i] & ~pop_mask;
        blk_r[i]   <= blk_r[i] & ~clr_blk;
      end
      if (push) begin
        older_r[free_idx] <= valid_r & ~pop_mask;
        blk_r[free_idx]   <= push_blk & ~clr_blk;
      end
    end
  end

  a_pick_eligible:
  assert property (@(posedge pclk) disable iff (!presetn)
    pop && sel_valid |-> blk_r[sel_idx] == '0)
    else $error("Queue released a command still held by a conflict.");

  a_pick_urgent:
  assert property (@(posedge pclk) disable iff (!presetn)
    pop && sel_valid |-> !(elig[0] && slot_r[0].prio < sel_cmd.prio) &&
      !(elig[1] && slot_r[1].prio < sel_cmd.prio) &&
      !(elig[2] && slot_r[2].prio < sel_cmd.prio) &&
      !(elig[3] && slot_r[3].prio < sel_cmd.prio))
    else $error("Queue released a less urgent command first.");

  a_pick_oldest:
  assert property (@(posedge pclk) disable iff (!presetn)
    pop && sel_valid |-> ((older_r[sel_idx] & elig) == '0) ||
      !((older_r[sel_idx][0] && elig[0] && slot_r[0].prio == sel_cmd.prio)
      || (older_r[sel_idx][1] && elig[1] && slot_r[1].prio == sel_cmd.prio)
      || (older_r[sel_idx][2] && elig[2] && slot_r[2].prio == sel_cmd.prio)
      || (older_r[sel_idx][3] && elig[3] &&
          slot_r[3].prio == sel_cmd.prio)))
    else $error("Queue passed an older command of equal priority.");
endmodule
`default_nettype wire

// *** src/dqos_pkg.sv ***
// Shared constants and carrier types of the DRAM bridge QoS front end.
package dqos_pkg;
  localparam int unsigned DEPTH   = 4;
  localparam int unsigned IDX_W   = 2;
  localparam int unsigned CNT_W   = 3;
  localparam int unsigned ADDR_W  = 32;
  localparam int unsigned PADDR_W = 8;
  localparam int unsigned MAP_W   = 24;
  localparam int unsigned NRANGE  = 3;

  // Bus thread numbers of the two traffic classes.
  localparam logic [1:0] THREAD_REALTIME    = 2'h2;
  localparam logic [1:0] THREAD_NONREALTIME = 2'h0;

  // Register byte offsets.
  localparam logic [7:0] OFF_RANGE1   = 8'h00;
  localparam logic [7:0] OFF_MAP_BASE = 8'h0C;
  localparam logic [7:0] OFF_STATUS   = 8'h2C;

  // Range match register fields.
  localparam int unsigned RNG_LO_LSB = 0;
  localparam int unsigned RNG_HI_LSB = 4;
  localparam int unsigned RNG_EN_BIT = 8;
  localparam logic [8:0]  RNG_RESET  = 9'h000;
  localparam logic [8:0]  RNG_MASK   = 9'h177;

  // Priority map reset is the identity map, field p at bits 3p+2..3p.
  localparam logic [23:0] MAP_RESET = 24'hFA_C688;

  // Status register fields.
  localparam int unsigned ST_HI_CNT_LSB = 0;
  localparam int unsigned ST_LO_CNT_LSB = 4;
  localparam int unsigned ST_BLK_BIT    = 8;

  typedef struct packed {
    logic [1:0]        thread;
    logic [2:0]        prio;
    logic [ADDR_W-1:0] addr;
    logic              write;
  } dqos_bus_cmd_t;

  typedef struct packed {
    logic [2:0]        prio;
    logic [ADDR_W-1:0] addr;
    logic              write;
  } dqos_slot_t;

  typedef struct packed {
    logic              high_prio_thread;
    logic [2:0]        prio;
    logic [ADDR_W-1:0] addr;
    logic              write;
  } dqos_dram_cmd_t;
endpackage

// *** verification/dqos_dram_sink.sv ***
// DRAM controller model that takes issued commands and logs them.
`timescale 1ns/1ps
`default_nettype none
module dqos_dram_sink
  import dqos_pkg::*;
(
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     hold,
  input  wire logic                     slow,
  input  wire logic                     dram_valid,
  output logic                          dram_ready,
  input  wire dqos_pkg::dqos_dram_cmd_t dram_cmd
);
  dqos_dram_cmd_t log_q[$];

  // Ready is withheld while stalled and comes every other cycle when slow.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dram_ready <= 1'h0;
    end else begin
      dram_ready <= !hold && (!slow || !dram_ready);
      if (dram_valid && dram_ready) begin
        log_q.push_back(dram_cmd);
      end
    end
  end
endmodule
`default_nettype wire

// *** verification/test_ddr_bridge_qos_cos_mapper.sv ***
// Self-checking bench for the DRAM bridge QoS front end.
`timescale 1ns/1ps
`default_nettype none
module test_ddr_bridge_qos_cos_mapper;
  import dqos_pkg::*;
  logic               pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [PADDR_W-1:0] paddr;
  logic [31:0]        pwdata, prdata, rd;
  logic               cmd_valid, cmd_ready, dram_valid, dram_ready;
  logic               hold, slow, err, ok;
  dqos_bus_cmd_t      cmd_in;
  dqos_dram_cmd_t     dram_cmd, exp_q[$];
  int                 bad_count, n_tests, cyc, n, i;

  dqos_bridge dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_in(cmd_in),
    .dram_valid(dram_valid), .dram_ready(dram_ready), .dram_cmd(dram_cmd));

  dqos_dram_sink sink (.pclk(pclk), .presetn(presetn), .hold(hold),
    .slow(slow), .dram_valid(dram_valid), .dram_ready(dram_ready),
    .dram_cmd(dram_cmd));

  // Clock of 40 ns period.
  always #20 pclk = ~pclk;

  // Cuts a hang short after a fixed number of cycles.
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      report_and_stop();
    end
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    if (bad_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // One APB transfer; request held until pready is seen at an edge.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      rd = prdata;
      err = pslverr;
      ok = pready;
    end while (ok !== 1'h1);
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  // Reads a register and compares data and error response.
  task automatic rdchk(input logic [7:0] a, input logic [31:0] d,
                       input logic e);
    apb(1'h0, a, 32'h0000_0000);
    check(64'(rd), 64'(d));
    check(64'(err), 64'(e));
  endtask

  // Offers one command; ok tells whether it was taken within tries.
  task automatic send(input logic [1:0] t, input logic [2:0] p,
                      input logic [31:0] a, input int tries);
    int k;
    cmd_valid <= 1'h1;
    cmd_in <= '{t, p, a, 1'h0};
    ok = 1'h0;
    for (k = 0; k < tries && ok !== 1'h1; k++) begin
      @(posedge pclk);
      ok = cmd_ready;
    end
  endtask

  task automatic ex(input logic hp, input logic [2:0] p,
                    input logic [31:0] a);
    exp_q.push_back('{hp, p, a, 1'h0});
  endtask

  // Lets the sink run, then compares the issue order with the list.
  task automatic drain;
    int k;
    cmd_valid <= 1'h0;
    hold <= 1'h0;
    for (k = 0; k < 300 && sink.log_q.size() < exp_q.size(); k++) begin
      @(posedge pclk);
    end
    repeat (4) @(posedge pclk);
    check(64'(sink.log_q.size()), 64'(exp_q.size()));
    foreach (exp_q[j]) check(64'(sink.log_q[j]), 64'(exp_q[j]));
    sink.log_q = {};
    exp_q = {};
    hold <= 1'h1;
  endtask

  // Single command through the priority mapping.
  task automatic m(input logic [1:0] t, input logic [2:0] p,
                   input logic hp, input logic [2:0] e);
    send(t, p, 32'h0000_4000, 20);
    ex(hp, e, 32'h0000_4000);
    drain();
  endtask

  // Main sequence.
  initial begin
    pclk = 1'h0;
    presetn = 1'h0;
    {psel, penable, pwrite, cmd_valid, slow} = '0;
    {paddr, pwdata, cmd_in} = '0;
    hold = 1'h1;
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    // Reset values, masks, read-only status and refused addresses.
    for (i = 0; i < 11; i++) begin
      rdchk(8'(i * 4), (i < 3) ? 32'h0000_0000 : 32'h00FA_C688, 1'h0);
    end
    apb(1'h1, 8'h00, 32'hFFFF_FFFF);
    rdchk(8'h00, 32'h0000_0177, 1'h0);
    apb(1'h1, 8'h14, 32'hFFFF_FFFF);
    rdchk(8'h14, 32'h00FF_FFFF, 1'h0);
    apb(1'h1, 8'h2C, 32'hFFFF_FFFF);
    rdchk(8'h2C, 32'h0000_0000, 1'h0);
    apb(1'h1, 8'h30, 32'h0000_0001);
    check(64'(err), 64'h1);
    rdchk(8'h30, 32'h0000_0000, 1'h1);
    rdchk(8'h02, 32'h0000_0000, 1'h1);
    apb(1'h1, 8'h00, 32'h0000_0000);
    apb(1'h1, 8'h14, 32'h00FA_C688);
    // Thread sorting and overtaking behind a stalled output.
    send(2'h0, 3'h5, 32'h0000_00A1, 20);
    send(2'h0, 3'h6, 32'h0000_00A2, 20);
    send(2'h0, 3'h1, 32'h0000_00A3, 20);
    send(2'h1, 3'h0, 32'h0000_00A4, 20);
    send(2'h2, 3'h7, 32'h0000_00A5, 20);
    send(2'h2, 3'h3, 32'h0000_00A6, 20);
    ex(1'h0, 3'h5, 32'h0000_00A1);
    ex(1'h1, 3'h3, 32'h0000_00A6);
    ex(1'h1, 3'h7, 32'h0000_00A5);
    ex(1'h0, 3'h0, 32'h0000_00A4);
    ex(1'h0, 3'h1, 32'h0000_00A3);
    ex(1'h0, 3'h6, 32'h0000_00A2);
    drain();
    // Address conflict holds a high command; slow sink.
    slow <= 1'h1;
    send(2'h0, 3'h4, 32'h0000_0200, 20);
    send(2'h0, 3'h4, 32'h0000_0100, 20);
    send(2'h2, 3'h0, 32'h0000_0100, 20);
    send(2'h2, 3'h5, 32'h0000_0300, 20);
    cmd_valid <= 1'h0;
    rdchk(8'h2C, 32'h0000_0112, 1'h0);
    ex(1'h0, 3'h4, 32'h0000_0200);
    ex(1'h1, 3'h5, 32'h0000_0300);
    ex(1'h0, 3'h4, 32'h0000_0100);
    ex(1'h1, 3'h0, 32'h0000_0100);
    drain();
    slow <= 1'h0;
    // Fill the low thread until refused; high space stays reserved.
    n = 0;
    do begin
      send(2'h0, 3'h2, 32'h0000_1000 + 32'(n * 4), 1);
      if (ok === 1'h1) n++;
    end while (ok === 1'h1 && n < 8);
    check(64'(n), 64'(DEPTH + 1));
    send(2'h2, 3'h0, 32'h0000_2000, 3);
    check(64'(ok), 64'h1);
    ex(1'h0, 3'h2, 32'h0000_1000);
    ex(1'h1, 3'h0, 32'h0000_2000);
    for (i = 1; i < 5; i++) ex(1'h0, 3'h2, 32'h0000_1000 + 32'(i * 4));
    drain();
    // Range matches and priority maps.
    apb(1'h1, 8'h00, 32'h0000_0142);
    apb(1'h1, 8'h04, 32'h0000_0133);
    apb(1'h1, 8'h08, 32'h0000_0176);
    apb(1'h1, 8'h10, 32'h0005_3977);
    apb(1'h1, 8'h14, 32'h00DB_6DB6);
    apb(1'h1, 8'h28, 32'h0024_9249);
    apb(1'h1, 8'h1C, 32'h0049_2492);
    m(2'h0, 3'h3, 1'h0, 3'h4);
    m(2'h0, 3'h2, 1'h0, 3'h5);
    m(2'h2, 3'h7, 1'h1, 3'h1);
    m(2'h2, 3'h1, 1'h1, 3'h2);
    m(2'h2, 3'h3, 1'h1, 3'h3);
    apb(1'h1, 8'h00, 32'h0000_0042);
    m(2'h0, 3'h3, 1'h0, 3'h6);
    report_and_stop();
  end
endmodule
`default_nettype wire
